// ---- ebcd_pkg.sv ----
// package: constants for the external bus configuration decoder
package ebcd_pkg;
  // apb register map (byte addresses)
  localparam logic [7:0] ADDR_CFG_BYTE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DECODE = 8'h0C;
  // configuration byte field positions
  localparam int BIT_RSVD = 7;
  localparam int BIT_WSA_HI = 6;
  localparam int BIT_WSA_LO = 5;
  localparam int BIT_LATCH_PULSE_EXTEND = 4;
  localparam int BIT_MSS_HI = 3;
  localparam int BIT_MSS_LO = 2;
  localparam int BIT_PAGE = 1;
  localparam int BIT_SRC = 0;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  // wait state counts
  localparam logic [1:0] WAIT_00 = 2'h3;
  localparam logic [1:0] WAIT_01 = 2'h2;
  localparam logic [1:0] WAIT_10 = 2'h1;
  localparam logic [1:0] WAIT_11 = 2'h0;
  // latch pulse widths in oscillator periods
  localparam logic [1:0] ALE_LONG = 2'h3;
  localparam logic [1:0] ALE_SHORT = 2'h1;
  // address widths
  localparam logic [4:0] AW_18 = 5'h12;
  localparam logic [4:0] AW_17 = 5'h11;
  localparam logic [4:0] AW_16 = 5'h10;
  // memory regions
  localparam logic [7:0] REG_00 = 8'h00;
  localparam logic [7:0] REG_01 = 8'h01;
  localparam logic [7:0] REG_FE = 8'hFE;
  localparam logic [7:0] REG_FF = 8'hFF;
  // fetch sequencer states
  typedef enum logic [3:0] {
    EBCD_IDLE   = 4'h1,
    EBCD_FETCH1 = 4'h2,
    EBCD_FETCH2 = 4'h4,
    EBCD_DONE   = 4'h8
  } ebcd_state_t;
endpackage : ebcd_pkg

// ---- ebcd_decode.sv ----
// module: combinational decode of the configuration byte
`timescale 1ns/1ps
module ebcd_decode (
  input wire logic [7:0] cfg_i,
  output logic [1:0] wait_states_o,
  output logic [1:0] ale_width_o,
  output logic [4:0] addr_width_o,
  output logic page_mode_o,
  output logic source_mode_o
);
  logic [1:0] wsel;
  logic [1:0] msel;
  assign wsel = {cfg_i[ebcd_pkg::BIT_WSA_HI], cfg_i[ebcd_pkg::BIT_WSA_LO]};
  assign msel = {cfg_i[ebcd_pkg::BIT_MSS_HI], cfg_i[ebcd_pkg::BIT_MSS_LO]};
  // wait states, address width and bus mode decode
  always_comb begin
    case (wsel)
      2'h0: wait_states_o = ebcd_pkg::WAIT_00;
      2'h1: wait_states_o = ebcd_pkg::WAIT_01;
      2'h2: wait_states_o = ebcd_pkg::WAIT_10;
      default: wait_states_o = ebcd_pkg::WAIT_11;
    endcase
    case (msel)
      2'h0: addr_width_o = ebcd_pkg::AW_18;
      2'h1: addr_width_o = ebcd_pkg::AW_17;
      default: addr_width_o = ebcd_pkg::AW_16;
    endcase
    ale_width_o = cfg_i[ebcd_pkg::BIT_LATCH_PULSE_EXTEND] ? ebcd_pkg::ALE_SHORT
                                            : ebcd_pkg::ALE_LONG;
    page_mode_o = ~cfg_i[ebcd_pkg::BIT_PAGE];
    source_mode_o = cfg_i[ebcd_pkg::BIT_SRC];
  end
endmodule : ebcd_decode

// ---- ebcd_top.sv ----
// module: external bus configuration decoder with apb access
`timescale 1ns/1ps
module ebcd_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // configuration fetch from non-volatile storage
  input wire logic [7:0] cfg_data_i,
  input wire logic port2_bit1_pin_i,
  // access under way: region and address from the core
  input wire logic [7:0] region_i,
  input wire logic [17:0] addr_i,
  // decoded settings
  output logic [1:0] wait_states_o,
  output logic [1:0] ale_width_o,
  output logic [4:0] addr_width_o,
  output logic page_mode_o,
  output logic source_mode_o,
  output logic port1_bit7_pin_o,
  output logic port1_bit7_pin_oe_o,
  output logic port3_bit7_pin_o,
  output logic port3_bit7_pin_oe_o,
  output logic p37_is_rd_o,
  output logic program_strobe_n_reads_o,
  output logic cfg_valid_o
);
  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [7:0] cfg_s1_reg;
  logic [7:0] cfg_s2_reg;
  logic p21_s1_reg;
  logic p21_s2_reg;
  // two-stage capture of pins from outside the clock domain
  // kept running through reset so the first fetch sees settled straps
  always_ff @(posedge mclk_i) begin
    cfg_s1_reg <= cfg_data_i;
    cfg_s2_reg <= cfg_s1_reg;
    p21_s1_reg <= port2_bit1_pin_i;
    p21_s2_reg <= p21_s1_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // fetch sequencer
  ebcd_pkg::ebcd_state_t state_reg;
  ebcd_pkg::ebcd_state_t state_next;
  logic [7:0] cfg_reg;
  logic page_fetch_reg;
  logic refetch_req;
  // state advance: two fetches after reset or on software request
  always_comb begin
    case (state_reg)
      ebcd_pkg::EBCD_IDLE: state_next = ebcd_pkg::EBCD_FETCH1;
      ebcd_pkg::EBCD_FETCH1: state_next = ebcd_pkg::EBCD_FETCH2;
      ebcd_pkg::EBCD_FETCH2: state_next = ebcd_pkg::EBCD_DONE;
      ebcd_pkg::EBCD_DONE: state_next = refetch_req ? ebcd_pkg::EBCD_IDLE
                                                     : ebcd_pkg::EBCD_DONE;
      default: state_next = ebcd_pkg::EBCD_IDLE;
    endcase
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ebcd_pkg::EBCD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  // capture byte; port2 bit1 at first fetch selects page mode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg <= ebcd_pkg::CFG_RESET;
      page_fetch_reg <= 1'b0;
    end else if (state_reg == ebcd_pkg::EBCD_FETCH1) begin
      page_fetch_reg <= ~p21_s2_reg;
      cfg_reg <= cfg_s2_reg;
    end else if (state_reg == ebcd_pkg::EBCD_FETCH2) begin
      // second fetch keeps page bit per first-fetch strap
      cfg_reg <= {cfg_s2_reg[7:2], ~page_fetch_reg, cfg_s2_reg[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode
  logic [1:0] dec_wait;
  logic [1:0] dec_ale;
  logic [4:0] dec_aw;
  logic dec_page;
  logic dec_src;
  ebcd_decode u_decode (
    .cfg_i(cfg_reg),
    .wait_states_o(dec_wait),
    .ale_width_o(dec_ale),
    .addr_width_o(dec_aw),
    .page_mode_o(dec_page),
    .source_mode_o(dec_src)
  );
  logic [1:0] msel;
  logic cfg_valid;
  assign msel = {cfg_reg[ebcd_pkg::BIT_MSS_HI], cfg_reg[ebcd_pkg::BIT_MSS_LO]};
  assign cfg_valid = (state_reg == ebcd_pkg::EBCD_DONE);

  ////////////////////////////////////////////////////////////////////////
  // registered outputs for the external bus
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_states_o <= ebcd_pkg::WAIT_00;
      ale_width_o <= ebcd_pkg::ALE_LONG;
      addr_width_o <= ebcd_pkg::AW_16;
      page_mode_o <= 1'b0;
      source_mode_o <= 1'b0;
      cfg_valid_o <= 1'b0;
    end else begin
      // region 01 never takes the configured count
      wait_states_o <= (region_i == ebcd_pkg::REG_01) ? ebcd_pkg::WAIT_11
                                                       : dec_wait;
      ale_width_o <= dec_ale;
      addr_width_o <= dec_aw;
      page_mode_o <= dec_page;
      source_mode_o <= dec_src;
      cfg_valid_o <= cfg_valid;
    end
  end
  // pin roles for port1 bit7 and port3 bit7 and the strobes
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      port1_bit7_pin_o <= 1'b0;
      port1_bit7_pin_oe_o <= 1'b0;
      port3_bit7_pin_o <= 1'b0;
      port3_bit7_pin_oe_o <= 1'b0;
      p37_is_rd_o <= 1'b0;
      program_strobe_n_reads_o <= 1'b0;
    end else begin
      case (msel)
        2'h0: begin
          port1_bit7_pin_o <= addr_i[17];
          port1_bit7_pin_oe_o <= 1'b1;
          port3_bit7_pin_o <= addr_i[16];
          port3_bit7_pin_oe_o <= 1'b1;
          p37_is_rd_o <= 1'b0;
          program_strobe_n_reads_o <= 1'b1;
        end
        2'h1: begin
          port1_bit7_pin_o <= 1'b0;
          port1_bit7_pin_oe_o <= 1'b0;
          port3_bit7_pin_o <= addr_i[16];
          port3_bit7_pin_oe_o <= 1'b1;
          p37_is_rd_o <= 1'b0;
          program_strobe_n_reads_o <= 1'b1;
        end
        2'h2: begin
          port1_bit7_pin_o <= 1'b0;
          port1_bit7_pin_oe_o <= 1'b0;
          port3_bit7_pin_o <= 1'b0;
          port3_bit7_pin_oe_o <= 1'b0;
          p37_is_rd_o <= 1'b0;
          program_strobe_n_reads_o <= 1'b1;
        end
        default: begin
          // separate data and code spaces
          port1_bit7_pin_o <= 1'b0;
          port1_bit7_pin_oe_o <= 1'b0;
          port3_bit7_pin_o <= 1'b0;
          port3_bit7_pin_oe_o <= 1'b0;
          p37_is_rd_o <= (region_i == ebcd_pkg::REG_00) ||
                         (region_i == ebcd_pkg::REG_01);
          program_strobe_n_reads_o <= (region_i == ebcd_pkg::REG_FE) ||
                          (region_i == ebcd_pkg::REG_FF);
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait
  logic apb_access;
  logic apb_wr;
  logic hit;
  logic [31:0] rdata;
  assign apb_access = psel_i & penable_i;
  assign apb_wr = apb_access & pwrite_i;
  assign refetch_req = apb_wr & (paddr_i == ebcd_pkg::ADDR_CTRL) & pwdata_i[0];
  // read mux
  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr_i)
      ebcd_pkg::ADDR_CFG_BYTE: rdata = {24'h00_0000, cfg_reg};
      ebcd_pkg::ADDR_CTRL: rdata = 32'h0000_0000;
      ebcd_pkg::ADDR_STATUS:
        rdata = {27'h000_0000, state_reg, cfg_valid};
      ebcd_pkg::ADDR_DECODE:
        rdata = {21'h00_0000, dec_aw, dec_ale, dec_wait, dec_page, dec_src};
      default: hit = 1'b0;
    endcase
  end
  // answer in the access cycle; writes to read-only words flag an error
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rdata : 32'h0000_0000;
      pslverr_o <= psel_i & ~penable_i &
                   (~hit | (pwrite_i & (paddr_i != ebcd_pkg::ADDR_CTRL)));
    end
  end
endmodule : ebcd_top

// ---- ebcd_cfg_store.sv ----
// partner: boot configuration storage and strap pin model
`timescale 1ns/1ps
module ebcd_cfg_store (
  input wire logic [7:0] cfg_byte_i,
  input wire logic strap_i,
  output logic [7:0] cfg_data_o,
  output logic strap_o
);
  // the programmer always writes the reserved top bit as one
  assign cfg_data_o = {1'h1, cfg_byte_i[6:0]};
  // strap level that the first fetch sees
  assign strap_o = strap_i;
endmodule : ebcd_cfg_store

// ---- ebcd_chk_sva.sv ----
// checker: port level assertions for the config decoder
`timescale 1ns/1ps
module ebcd_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] region_i,
  input wire logic [17:0] addr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [1:0] wait_states_o,
  input wire logic [1:0] ale_width_o,
  input wire logic [4:0] addr_width_o,
  input wire logic port1_bit7_pin_o,
  input wire logic port1_bit7_pin_oe_o,
  input wire logic port3_bit7_pin_o,
  input wire logic port3_bit7_pin_oe_o,
  input wire logic p37_is_rd_o,
  input wire logic program_strobe_n_reads_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  // live: the previous edge was already out of reset
  logic live;
  logic a17;
  logic a16;
  assign a17 = addr_i[17];
  assign a16 = addr_i[16];
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) live <= 1'h0;
    else live <= 1'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  property p_wait01;
    live && $past(region_i) == ebcd_pkg::REG_01 |-> wait_states_o == 2'h0;
  endproperty
  a_wait01: assert property (p_wait01) else $error("wait in region 01");
  property p_ale;
    ale_width_o == 2'h3 || ale_width_o == 2'h1;
  endproperty
  a_ale: assert property (p_ale) else $error("latch width");
  property p_p1oe;
    live |-> port1_bit7_pin_oe_o == (addr_width_o == ebcd_pkg::AW_18);
  endproperty
  a_p1oe: assert property (p_p1oe) else $error("p1.7 enable");
  property p_aw17;
    addr_width_o == ebcd_pkg::AW_17 |-> port3_bit7_pin_oe_o;
  endproperty
  a_aw17: assert property (p_aw17) else $error("p3.7 in 17 bit");
  property p_p1d;
    live && port1_bit7_pin_oe_o |-> port1_bit7_pin_o == $past(a17);
  endproperty
  a_p1d: assert property (p_p1d) else $error("p1.7 address");
  property p_p3d;
    live && addr_width_o != ebcd_pkg::AW_16 |->
      port3_bit7_pin_oe_o && port3_bit7_pin_o == $past(a16);
  endproperty
  a_p3d: assert property (p_p3d) else $error("p3.7 address");
  property p_rd;
    live && p37_is_rd_o |-> addr_width_o == ebcd_pkg::AW_16 &&
      $past(region_i) < 8'h02;
  endproperty
  a_rd: assert property (p_rd) else $error("p3.7 read strobe");
  property p_program_strobe_n;
    live && !program_strobe_n_reads_o |-> $past(region_i) < 8'hFE;
  endproperty
  a_program_strobe_n: assert property (p_program_strobe_n) else $error("program strobe");
  property p_rdy;
    psel_i && !penable_i |=> pready_o ##1 !pready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("apb ready timing");
  property p_err;
    pslverr_o |-> pready_o;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  // main scenarios
  c_rd: cover property (p37_is_rd_o);
  c_aw18: cover property (addr_width_o == ebcd_pkg::AW_18);
  c_err: cover property (pslverr_o);
endmodule : ebcd_chk
bind ebcd_top ebcd_chk u_chk (.*);

// ---- tb_top.sv ----
// testbench: config byte decode, pins and apb register access
`timescale 1ns/1ps
module tb_top;
  logic mclk_i = 1'h0, rst_i = 1'h1, psel_i = '0, penable_i = '0;
  logic pwrite_i = '0, port2_bit1_pin_i, st_strap = 1'h1;
  logic [7:0] paddr_i = '0, region_i = '0, st_byte = 8'hFF, cfg_data_i;
  logic [31:0] pwdata_i = '0, prdata_o;
  logic [17:0] addr_i = '0;
  logic pready_o, pslverr_o, page_mode_o, source_mode_o, cfg_valid_o;
  logic port1_bit7_pin_o, port1_bit7_pin_oe_o, port3_bit7_pin_o;
  logic port3_bit7_pin_oe_o, p37_is_rd_o, program_strobe_n_reads_o;
  logic [1:0] wait_states_o, ale_width_o;
  logic [4:0] addr_width_o;
  logic [31:0] r;
  logic e;
  int fails = 0, checks = 0;
  localparam logic [7:0] REGS [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};
  ebcd_top dut (.*);
  ebcd_cfg_store u_store (.cfg_byte_i(st_byte), .strap_i(st_strap),
    .cfg_data_o(cfg_data_i), .strap_o(port2_bit1_pin_i));
  initial forever #2.5 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // one apb transfer, waits for ready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 20);
    if (n >= 20) begin
      fails++;
      test_done();
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask : apb
  // reset with a stored byte, then time the fetch sequence
  task boot(input logic [7:0] b, input logic s);
    int k;
    st_byte <= b;
    st_strap <= s;
    rst_i <= 1'h1;
    repeat (12) @(posedge mclk_i);
    cmp({wait_states_o, ale_width_o, addr_width_o}, 32'h1F0);
    rst_i <= 1'h0;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (cfg_valid_o !== 1'h1 && k < 20);
    cmp(k == 4 || k == 5, 32'h1);
    if (k >= 20) test_done();
  endtask : boot
  // decoded settings, pins and registers for one byte
  task chk_cfg(input logic [7:0] b);
    logic [1:0] w;
    logic [4:0] aw;
    w = 2'h3 - b[6:5];
    aw = b[3] ? 5'h10 : (b[2] ? 5'h11 : 5'h12);
    foreach (REGS[i]) begin
      region_i <= REGS[i];
      addr_i <= 18'h30000;
      repeat (2) @(posedge mclk_i);
      cmp(wait_states_o, REGS[i] == 8'h01 ? 2'h0 : w);
      cmp(p37_is_rd_o, b[3:2] == 2'h3 && REGS[i] < 8'h02);
      cmp(program_strobe_n_reads_o, b[3:2] != 2'h3 || REGS[i] > 8'hFD);
    end
    cmp(port1_bit7_pin_oe_o, b[3:2] == 2'h0);
    if (b[3:2] == 2'h0) cmp(port1_bit7_pin_o, 32'h1);
    cmp(port3_bit7_pin_o, b[3] == 1'h0);
    if (b[3:2] == 2'h2) cmp(port3_bit7_pin_oe_o, 32'h0);
    cmp(ale_width_o, b[4] ? 2'h1 : 2'h3);
    cmp(addr_width_o, aw);
    cmp({page_mode_o, source_mode_o}, {~b[1], b[0]});
    apb(1'h0, 8'h00, 32'h0);
    cmp(r, {24'h0, b});
    cmp(e, 32'h0);
    apb(1'h0, 8'h0C, 32'h0);
    cmp(r, {21'h0, aw, b[4] ? 2'h1 : 2'h3, w, ~b[1], b[0]});
    $display("test cfg %h done", b);
  endtask : chk_cfg
  // refused accesses, then a refetch through the control register
  task t_refuse;
    apb(1'h1, 8'h00, 32'h0);
    cmp(e, 32'h1);
    apb(1'h0, 8'h10, 32'h0);
    cmp(e, 32'h1);
    st_byte <= 8'hA9;
    apb(1'h1, 8'h04, 32'h1);
    cmp(e, 32'h0);
    repeat (6) @(posedge mclk_i);
    chk_cfg(8'hA9);
    $display("test refuse done");
  endtask : t_refuse
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot({1'h1, i[1:0], i[0], i[1:0], 1'h1, i[1]}, 1'h1);
      chk_cfg({1'h1, i[1:0], i[0], i[1:0], 1'h1, i[1]});
    end
    boot(8'hFD, 1'h0);
    chk_cfg(8'hFD);
    t_refuse();
    test_done();
  end
endmodule : tb_top
